/* inc/uart_irq_pkg.sv */
// Package for the UART channel interrupt prioritisation block
package uart_irq_pkg;
   // Register byte offsets on the APB bus
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h00;
   localparam logic [7:0] OFS_IRQ_SOURCE = 8'h04;
   localparam logic [7:0] OFS_FIFO_CTRL = 8'h08;
   localparam logic [7:0] OFS_LINE_STATUS = 8'h0c;
   localparam logic [7:0] OFS_MODEM_STATUS = 8'h10;
   localparam logic [7:0] OFS_FEATURE_CTRL = 8'h14;
   localparam logic [7:0] OFS_EXT_MODEM_STATUS = 8'h18;
   localparam logic [7:0] OFS_RX_HOLDING = 8'h1c;
   localparam logic [7:0] OFS_TX_HOLDING = 8'h20;
   // Field positions
   localparam int IE_RX_DATA = 0;
   localparam int IE_TX_READY = 1;
   localparam int IE_LINE = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_XOFF = 5;
   localparam int IE_RTS = 6;
   localparam int IE_CTS = 7;
   localparam int FC_ENHANCED = 4;
   localparam int EMS_IMMEDIATE_ERR = 6;
   // Reset values
   localparam logic [7:0] IRQ_ENABLE_RST = 8'h00;
   localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
   localparam logic [7:0] FEATURE_CTRL_RST = 8'h00;
   localparam logic [7:0] EXT_MODEM_RST = 8'h00;
   // Source codes, bits 5..0
   localparam logic [5:0] SRC_LINE = 6'h06;
   localparam logic [5:0] SRC_TIMEOUT = 6'h0c;
   localparam logic [5:0] SRC_RX_READY = 6'h04;
   localparam logic [5:0] SRC_TX_READY = 6'h02;
   localparam logic [5:0] SRC_MODEM = 6'h00;
   localparam logic [5:0] SRC_XOFF = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   localparam logic [5:0] SRC_NONE = 6'h01;

   // Events from the receive and transmit datapaths
   typedef struct packed {
      logic rx_char_in;
      logic rx_at_trigger;
      logic rx_not_empty;
      logic rx_timeout;
      logic rx_overrun;
      logic [2:0] head_err;
      logic head_pop;
      logic any_err;
      logic thr_empty;
      logic tx_below_trigger;
      logic tx_all_empty;
      logic half_duplex;
      logic xoff_match;
      logic xon_match;
      logic special_match;
      logic [3:0] modem_delta;
   } dp_events_t;
endpackage

/* src/uart_irq_logic.sv */
// Interrupt enable, priority, source and status logic of one UART channel
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
//
// Contract
// - Rx ready irq: holding full, or FIFO at trigger; clears below it
// - Data ready flag sets on char into FIFO, clears when empty
// - FIFOs on with enables 0-3 off gives polled mode via line status
// - Line status bits report overrun, head errors, tx empties, any error
// - Tx ready irq on holding empty or below trigger; fires on enabling
// - Line irq from status 1-4; overrun at once, errors at read-out
// - Extended modem status bit 6 makes error interrupts immediate
// - Modem irq raised by any modem status delta bit 0-3
// - Enable bits 4-7 writable only with feature bit 4; reset zero
// - Source bit 4 flags Xoff or special match when enable 5 set
// - Enable 6 raises irq on rising request-to-send in auto mode
// - Enable 7 raises irq on rising clear-to-send in auto mode
// - Source read returns only the highest pending level
// - Rx timeout irq from timer with data pending; rx read clears
// - Tx ready from trigger or empty; fully empty in half duplex
// - Tx ready clears on source read or holding write
// - Line read clears line irq; modem read clears modem and pin irqs
// - Xoff clears on source read or Xon; special on read or next char
// - Priority codes levels 1 to 7, none reads 000001
// - Source bit 0 low while pending, high when idle
// - Source bit 5 flags pin change, active with enable 6 or 7
// - Source bits 7:6 read 11 with FIFOs on, 00 otherwise
// - FIFO control loads the written value only with bit 0 set; with bit 0 clear it resets and FIFOs turn off
module uart_irq_logic
   import uart_irq_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dp_events_t dp_ev,
   input wire logic rts_pin,
   input wire logic cts_pin,
   input wire logic auto_rts_en,
   input wire logic auto_cts_en,
   output logic irq_q,
   output logic fifo_en_q,
   output logic [7:0] fifo_ctrl_q,
   output logic rx_read_q,
   output logic tx_write_q,
   output logic [7:0] tx_data_q
);
   logic [7:0] irq_enable_q;
   logic [7:0] feature_ctrl_q;
   logic [7:0] ext_modem_q;
   logic data_ready_q, overrun_q, any_err_q;
   logic [2:0] head_err_q;
   logic line_pend_q, tx_pend_q, modem_pend_q, xoff_pend_q, spec_pend_q, flow_pend_q;
   logic [3:0] modem_delta_q;
   logic [1:0] cts_sync_q, rts_sync_q;
   logic cts_prev_q, rts_prev_q;
   logic thr_prev_q;
   logic [5:0] src_code;
   logic acc, wr, rd;
   logic rd_source, rd_line, rd_modem, rd_rx, wr_tx, wr_ier;
   logic tx_cond, rx_ready_pend, timeout_pend, err_now;
   logic cts_rise, rts_rise;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ==========================================================
   // Bus decode
   // Zero wait states once out of reset, from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else if (clk_en) begin
         pready <= 1'b1;
      end
   end
   assign acc = psel && penable && clk_en;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;
   assign rd_source = rd && hit(paddr, OFS_IRQ_SOURCE);
   assign rd_line = rd && hit(paddr, OFS_LINE_STATUS);
   assign rd_modem = rd && hit(paddr, OFS_MODEM_STATUS);
   assign rd_rx = rd && hit(paddr, OFS_RX_HOLDING);
   assign wr_tx = wr && hit(paddr, OFS_TX_HOLDING);
   assign wr_ier = wr && hit(paddr, OFS_IRQ_ENABLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pslverr <= psel && !penable && !(hit(paddr, OFS_IRQ_ENABLE) ||
            hit(paddr, OFS_IRQ_SOURCE) || hit(paddr, OFS_FIFO_CTRL) ||
            hit(paddr, OFS_LINE_STATUS) || hit(paddr, OFS_MODEM_STATUS) ||
            hit(paddr, OFS_FEATURE_CTRL) || hit(paddr, OFS_EXT_MODEM_STATUS) ||
            hit(paddr, OFS_RX_HOLDING) || hit(paddr, OFS_TX_HOLDING));
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_q <= IRQ_ENABLE_RST;
      end else if (clk_en && wr_ier) begin
         irq_enable_q[3:0] <= pwdata[3:0];
         if (feature_ctrl_q[FC_ENHANCED])
            irq_enable_q[7:4] <= pwdata[7:4];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fifo_ctrl_q <= FIFO_CTRL_RST;
         fifo_en_q <= 1'b0;
      end else if (clk_en && wr && hit(paddr, OFS_FIFO_CTRL)) begin
         fifo_en_q <= pwdata[0];
         if (pwdata[0])
            fifo_ctrl_q <= pwdata[7:0];
         else
            fifo_ctrl_q <= FIFO_CTRL_RST;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         feature_ctrl_q <= FEATURE_CTRL_RST;
         ext_modem_q <= EXT_MODEM_RST;
      end else if (clk_en) begin
         if (wr && hit(paddr, OFS_FEATURE_CTRL))
            feature_ctrl_q <= pwdata[7:0];
         if (wr && hit(paddr, OFS_EXT_MODEM_STATUS))
            ext_modem_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_read_q <= 1'b0;
         tx_write_q <= 1'b0;
         tx_data_q <= 8'h00;
      end else if (clk_en) begin
         rx_read_q <= rd_rx;
         tx_write_q <= wr_tx;
         if (wr_tx)
            tx_data_q <= pwdata[7:0];
      end
   end

   // ==========================================================
   // Line status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_ready_q <= 1'b0;
         overrun_q <= 1'b0;
         head_err_q <= 3'h0;
         any_err_q <= 1'b0;
      end else if (clk_en) begin
         // set on arrival wins over empty
         if (dp_ev.rx_char_in)
            data_ready_q <= 1'b1;
         else if (!dp_ev.rx_not_empty)
            data_ready_q <= 1'b0;
         // sticky error bits, set wins over read clear
         if (dp_ev.rx_overrun)
            overrun_q <= 1'b1;
         else if (rd_line)
            overrun_q <= 1'b0;
         if (|dp_ev.head_err)
            head_err_q <= head_err_q | dp_ev.head_err;
         else if (rd_line)
            head_err_q <= 3'h0;
         if (dp_ev.any_err)
            any_err_q <= 1'b1;
         else if (rd_line)
            any_err_q <= 1'b0;
      end
   end

   // ==========================================================
   // Pin synchronisers and edge detect
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cts_sync_q <= 2'b00;
         rts_sync_q <= 2'b00;
         cts_prev_q <= 1'b0;
         rts_prev_q <= 1'b0;
      end else if (clk_en) begin
         cts_sync_q <= {cts_sync_q[0], cts_pin};
         rts_sync_q <= {rts_sync_q[0], rts_pin};
         cts_prev_q <= cts_sync_q[1];
         rts_prev_q <= rts_sync_q[1];
      end
   end
   assign cts_rise = cts_sync_q[1] && !cts_prev_q;
   assign rts_rise = rts_sync_q[1] && !rts_prev_q;

   // ==========================================================
   // Pending sources
   // immediate error reporting select
   assign err_now = ext_modem_q[EMS_IMMEDIATE_ERR] ? (|dp_ev.head_err)
                                                  : (dp_ev.head_pop && |dp_ev.head_err);
   assign tx_cond = dp_ev.half_duplex ? dp_ev.tx_all_empty :
                    fifo_en_q ? dp_ev.tx_below_trigger : dp_ev.thr_empty;
   assign rx_ready_pend = irq_enable_q[IE_RX_DATA] &&
      (fifo_en_q ? dp_ev.rx_at_trigger : dp_ev.rx_not_empty);
   // timer from datapath, cleared on rx read
   logic timeout_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         timeout_q <= 1'b0;
      else if (clk_en) begin
         if (dp_ev.rx_timeout && dp_ev.rx_not_empty)
            timeout_q <= 1'b1;
         else if (rd_rx)
            timeout_q <= 1'b0;
      end
   end
   assign timeout_pend = irq_enable_q[IE_RX_DATA] && timeout_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_pend_q <= 1'b0;
         tx_pend_q <= 1'b0;
         thr_prev_q <= 1'b0;
      end else if (clk_en) begin
         // overrun at once, errors per mode
         if (irq_enable_q[IE_LINE] && (dp_ev.rx_overrun || err_now))
            line_pend_q <= 1'b1;
         else if (rd_line || !irq_enable_q[IE_LINE])
            line_pend_q <= 1'b0;
         thr_prev_q <= tx_cond;
         if (irq_enable_q[IE_TX_READY] && tx_cond && !thr_prev_q)
            tx_pend_q <= 1'b1;
         else if (wr_ier && pwdata[IE_TX_READY] && !irq_enable_q[IE_TX_READY] && tx_cond)
            tx_pend_q <= 1'b1;
         else if (wr_tx || (rd_source && src_code == SRC_TX_READY) ||
                  !irq_enable_q[IE_TX_READY])
            tx_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_delta_q <= 4'h0;
         modem_pend_q <= 1'b0;
         flow_pend_q <= 1'b0;
      end else if (clk_en) begin
         // modem read clears modem and pin changes
         if (|dp_ev.modem_delta)
            modem_delta_q <= modem_delta_q | dp_ev.modem_delta;
         else if (rd_modem)
            modem_delta_q <= 4'h0;
         if (irq_enable_q[IE_MODEM] && |dp_ev.modem_delta)
            modem_pend_q <= 1'b1;
         else if (rd_modem)
            modem_pend_q <= 1'b0;
         if ((irq_enable_q[IE_RTS] && auto_rts_en && rts_rise) ||
             (irq_enable_q[IE_CTS] && auto_cts_en && cts_rise))
            flow_pend_q <= 1'b1;
         else if (rd_modem)
            flow_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xoff_pend_q <= 1'b0;
         spec_pend_q <= 1'b0;
      end else if (clk_en) begin
         // xon or source read clears xoff
         if (irq_enable_q[IE_XOFF] && dp_ev.xoff_match)
            xoff_pend_q <= 1'b1;
         else if (dp_ev.xon_match || (rd_source && src_code == SRC_XOFF))
            xoff_pend_q <= 1'b0;
         if (irq_enable_q[IE_XOFF] && dp_ev.special_match)
            spec_pend_q <= 1'b1;
         else if (dp_ev.rx_char_in || (rd_source && src_code == SRC_XOFF))
            spec_pend_q <= 1'b0;
      end
   end

   // ==========================================================
   // Priority encode
   // highest pending wins
   always_comb begin
      if (line_pend_q)
         src_code = SRC_LINE;
      else if (timeout_pend)
         src_code = SRC_TIMEOUT;
      else if (rx_ready_pend)
         src_code = SRC_RX_READY;
      else if (tx_pend_q)
         src_code = SRC_TX_READY;
      else if (modem_pend_q)
         src_code = SRC_MODEM;
      else if (xoff_pend_q || spec_pend_q)
         src_code = SRC_XOFF;
      else if (flow_pend_q && (irq_enable_q[IE_RTS] || irq_enable_q[IE_CTS]))
         src_code = SRC_FLOW;
      else
         src_code = SRC_NONE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         irq_q <= 1'b0;
      else if (clk_en)
         irq_q <= (src_code != SRC_NONE);
   end

   // ==========================================================
   // Read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         prdata <= 32'h0;
      else if (clk_en && psel && !penable && !pwrite) begin
         prdata <= 32'h0;
         case (paddr)
            OFS_IRQ_ENABLE: prdata[7:0] <= irq_enable_q;
            OFS_IRQ_SOURCE: prdata[7:0] <= {{2{fifo_en_q}}, src_code};
            OFS_LINE_STATUS: prdata[7:0] <= {any_err_q, dp_ev.tx_all_empty,
               dp_ev.thr_empty, head_err_q, overrun_q, data_ready_q};
            OFS_MODEM_STATUS: prdata[7:0] <= {4'h0, modem_delta_q};
            OFS_FEATURE_CTRL: prdata[7:0] <= feature_ctrl_q;
            OFS_EXT_MODEM_STATUS: prdata[7:0] <= ext_modem_q;
            default: prdata <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Checks
   a_idle_code: assert property (@(posedge pclk) disable iff (!presetn)
      (!line_pend_q && !timeout_pend && !rx_ready_pend && !tx_pend_q && !modem_pend_q
       && !xoff_pend_q && !spec_pend_q && !flow_pend_q) |-> src_code == SRC_NONE)
      else $error("source not idle");
   a_line_first: assert property (@(posedge pclk) disable iff (!presetn)
      line_pend_q |-> src_code == SRC_LINE) else $error("line not highest");
   a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && src_code != SRC_NONE |=> irq_q) else $error("irq missing");
   a_upper_locked: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && wr_ier && !feature_ctrl_q[FC_ENHANCED] |=> $stable(irq_enable_q[7:4]))
      else $error("upper enables changed");
   a_tx_clear: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && wr_tx && !(tx_cond && !thr_prev_q) |=> !tx_pend_q)
      else $error("tx pending not cleared");
   a_fifo_gate: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && wr && hit(paddr, OFS_FIFO_CTRL) && !pwdata[0] |=> !fifo_en_q)
      else $error("fifo enabled without bit 0");
   a_modem_clear: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && rd_modem && !(|dp_ev.modem_delta) |=> !modem_pend_q)
      else $error("modem pending kept");
   a_data_ready: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && dp_ev.rx_char_in |=> data_ready_q) else $error("data ready missed");
   c_line: cover property (@(posedge pclk) rd_source && src_code == SRC_LINE);
   c_tx: cover property (@(posedge pclk) rd_source && src_code == SRC_TX_READY);
   c_flow: cover property (@(posedge pclk) src_code == SRC_FLOW);
endmodule

/* verif/apb_host.sv */
// APB host model that drives the register bus of the interrupt block
`timescale 1ns/1ps
module apb_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // ====================================================
   // Bus transfer
   // Request held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      // Start on a rising edge so every change follows it
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 1000);
      r = (n < 1000) ? prdata : 32'hx;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

/* verif/uart_irq_logic_bench.sv */
// Self-checking bench of the channel interrupt block
`timescale 1ns/1ps
module uart_irq_logic_bench
   import uart_irq_pkg::*;
();
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, fifo_ctrl_q, tx_data_q;
   logic [31:0] pwdata, prdata;
   logic rts_pin, irq_q, fifo_en_q, rx_read_q, tx_write_q;
   logic cts_pin, auto_cts, auto_rts, clk_en;
   dp_events_t dp;
   logic [7:1] pend;
   logic fifo_on;
   int n_mismatch, checked;
   localparam logic [5:0] src_of [1:7] = '{SRC_LINE, SRC_TIMEOUT, SRC_RX_READY,
      SRC_TX_READY, SRC_MODEM, SRC_XOFF, SRC_FLOW};

   always #12.5 pclk = ~pclk;

   uart_irq_logic i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_ev(dp),
      .rts_pin(rts_pin), .cts_pin(cts_pin), .auto_rts_en(auto_rts), .auto_cts_en(auto_cts),
      .irq_q(irq_q), .fifo_en_q(fifo_en_q), .fifo_ctrl_q(fifo_ctrl_q),
      .rx_read_q(rx_read_q), .tx_write_q(tx_write_q), .tx_data_q(tx_data_q));

   apb_host i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   // ====================================================
   // Reference model and checks
   function automatic logic [7:0] src_exp();
      logic [5:0] c;
      c = SRC_NONE;
      for (int i = 7; i >= 1; i--)
         if (pend[i])
            c = src_of[i];
      return {fifo_on, fifo_on, c};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Read, compare, then apply the clearing side effect to the model
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic er;
      int top;
      i_host.xfer(1'b0, a, 32'h0, r, er);
      chk(r, e);
      top = 0;
      for (int i = 7; i >= 1; i--)
         if (pend[i])
            top = i;
      if (a == OFS_IRQ_SOURCE && (top == 4 || top == 6))
         pend[top] = 1'b0;
      if (a == OFS_LINE_STATUS)
         pend[1] = 1'b0;
      if (a == OFS_RX_HOLDING)
         pend[2] = 1'b0;
      if (a == OFS_MODEM_STATUS)
         {pend[7], pend[5]} = 2'b00;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic er;
      i_host.xfer(1'b1, a, d, r, er);
      if (a == OFS_TX_HOLDING)
         pend[4] = 1'b0;
   endtask

   // Let pending and irq settle, then compare the interrupt line
   task automatic sync();
      repeat (3) @(posedge pclk);
      #1;
      chk({31'h0, irq_q}, {31'h0, |pend});
   endtask

   // ====================================================
   // Watchdog
   initial begin
      #500000;
      n_mismatch++;
      report_and_stop();
   end

   // ====================================================
   // Main sequence
   initial begin
      logic [31:0] r;
      logic er;
      logic [7:0] b;
      logic [3:0] md;
      pclk = 1'b0;
      presetn = 1'b0;
      dp = '0;
      rts_pin = 1'b0;
      cts_pin = 1'b0;
      auto_cts = 1'b0;
      auto_rts = 1'b1;
      clk_en = 1'b1;
      pend = '0;
      fifo_on = 1'b0;
      n_mismatch = 0;
      checked = 0;
      void'($urandom(32'h5b796caf));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      sync();
      chk({24'h0, fifo_ctrl_q}, {24'h0, FIFO_CTRL_RST});
      rd(OFS_IRQ_ENABLE, {24'h0, IRQ_ENABLE_RST});
      rd(OFS_IRQ_SOURCE, src_exp());
      i_host.xfer(1'b0, 8'h3c, 32'h0, r, er);
      chk({31'h0, er}, 32'h1);
      chk(r, 32'h0);
      wr(OFS_FIFO_CTRL, 32'h06);
      #1;
      chk({23'h0, fifo_en_q, fifo_ctrl_q}, 32'h0);
      wr(OFS_FIFO_CTRL, 32'hc1);
      fifo_on = 1'b1;
      #1;
      chk({23'h0, fifo_en_q, fifo_ctrl_q}, 32'h1c1);
      rd(OFS_IRQ_SOURCE, src_exp());
      dp.rx_not_empty <= 1'b1;
      dp.thr_empty <= 1'b1;
      dp.tx_below_trigger <= 1'b1;
      dp.tx_all_empty <= 1'b1;
      dp.rx_char_in <= 1'b1;
      @(posedge pclk);
      dp.rx_char_in <= 1'b0;
      sync();
      rd(OFS_LINE_STATUS, 32'h61);
      wr(OFS_IRQ_ENABLE, 32'hff);
      pend[4] = 1'b1;
      rd(OFS_IRQ_ENABLE, 32'h0f);
      wr(OFS_FEATURE_CTRL, 32'h10);
      wr(OFS_IRQ_ENABLE, 32'hef);
      rd(OFS_IRQ_ENABLE, 32'hef);
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      md = 4'($urandom_range(15, 1));
      dp.rx_at_trigger <= 1'b1;
      dp.rx_timeout <= 1'b1;
      dp.rx_overrun <= 1'b1;
      dp.modem_delta <= md;
      dp.xoff_match <= 1'b1;
      @(posedge pclk);
      dp.rx_timeout <= 1'b0;
      dp.rx_overrun <= 1'b0;
      dp.modem_delta <= 4'h0;
      dp.xoff_match <= 1'b0;
      pend[3:1] = 3'b111;
      pend[6:5] = 2'b11;
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_LINE_STATUS, 32'h63);
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_RX_HOLDING, 32'h0);
      #1;
      chk({31'h0, rx_read_q}, 32'h1);
      rd(OFS_IRQ_SOURCE, src_exp());
      dp.rx_at_trigger <= 1'b0;
      pend[3] = 1'b0;
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      // Raise transmit ready again, then clear it by a holding write
      dp.tx_below_trigger <= 1'b0;
      @(posedge pclk);
      dp.tx_below_trigger <= 1'b1;
      pend[4] = 1'b1;
      sync();
      b = 8'($urandom);
      wr(OFS_TX_HOLDING, {24'h0, b});
      #1;
      chk({24'h0, tx_data_q}, {24'h0, b});
      chk({31'h0, tx_write_q}, 32'h1);
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_MODEM_STATUS, {28'h0, md});
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_IRQ_SOURCE, src_exp());
      sync();
      rts_pin <= 1'b1;
      pend[7] = 1'b1;
      repeat (3) @(posedge pclk);
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_MODEM_STATUS, 32'h0);
      rd(OFS_IRQ_SOURCE, src_exp());
      sync();
      // Rising clear-to-send under auto flow control
      auto_cts <= 1'b1;
      cts_pin <= 1'b1;
      pend[7] = 1'b1;
      repeat (3) @(posedge pclk);
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_MODEM_STATUS, 32'h0);
      // Head errors interrupt at read-out by default
      dp.head_err <= 3'h2;
      @(posedge pclk);
      dp.head_err <= 3'h0;
      sync();
      dp.head_err <= 3'h4;
      dp.head_pop <= 1'b1;
      @(posedge pclk);
      dp.head_err <= 3'h0;
      dp.head_pop <= 1'b0;
      pend[1] = 1'b1;
      sync();
      rd(OFS_LINE_STATUS, 32'h79);
      // Immediate error reporting
      wr(OFS_EXT_MODEM_STATUS, 32'h40);
      dp.head_err <= 3'h1;
      @(posedge pclk);
      dp.head_err <= 3'h0;
      pend[1] = 1'b1;
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      rd(OFS_LINE_STATUS, 32'h65);
      // Half duplex takes the fully empty transmitter
      dp.half_duplex <= 1'b1;
      dp.tx_all_empty <= 1'b0;
      @(posedge pclk);
      dp.tx_all_empty <= 1'b1;
      pend[4] = 1'b1;
      sync();
      rd(OFS_IRQ_SOURCE, src_exp());
      // Special cleared by the next char, Xoff by Xon
      dp.special_match <= 1'b1;
      @(posedge pclk);
      dp.special_match <= 1'b0;
      pend[6] = 1'b1;
      sync();
      dp.rx_char_in <= 1'b1;
      @(posedge pclk);
      dp.rx_char_in <= 1'b0;
      pend[6] = 1'b0;
      sync();
      dp.xoff_match <= 1'b1;
      @(posedge pclk);
      dp.xoff_match <= 1'b0;
      pend[6] = 1'b1;
      sync();
      dp.xon_match <= 1'b1;
      @(posedge pclk);
      dp.xon_match <= 1'b0;
      pend[6] = 1'b0;
      sync();
      // A low clock enable ignores a modem delta
      @(posedge pclk);
      clk_en <= 1'b0;
      dp.modem_delta <= 4'h1;
      @(posedge pclk);
      dp.modem_delta <= 4'h0;
      @(posedge pclk);
      clk_en <= 1'b1;
      sync();
      rd(OFS_MODEM_STATUS, 32'h0);
      report_and_stop();
   end
endmodule
